// File: ascs_i2c_mst.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bus master model with stretch handling
// ****************************************
module ascs_i2c_mst
(
  output var logic  SCL_CLK,
  output var logic  BUS_START,
  output wire logic SDA_IN,
  input  wire logic SDA_OE,
  input  wire logic SCL_OE
);
  logic mst_sda;
  logic oe_seen;
  int   stall_ns;
  initial
  begin
    SCL_CLK = 1'b1;
    BUS_START = 1'b0;
    mst_sda = 1'b1;
    oe_seen = 1'b0;
    stall_ns = 0;
  end
  // Device pull takes hold from the next clock fall
  always @(negedge SCL_CLK)
    oe_seen <= SDA_OE;
  // Pulled-up line: high unless either party pulls it low
  assign SDA_IN = mst_sda & ~oe_seen;
  // One bit; a stretched clock delays the rise, bounded
  task automatic clk_bit(input logic v, input logic st, output logic got);
    int guard;
    guard = 0;
    SCL_CLK = 1'b0;
    mst_sda = v;
    BUS_START = st;
    #(16 + stall_ns);
    while (SCL_OE !== 1'b0 && guard < 2000)
    begin
      #4;
      guard++;
    end
    got = SDA_IN;
    SCL_CLK = 1'b1;
    #16;
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] b, input logic st, input logic ackv,
                        output logic [7:0] got, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(b[i], st && i == 7, s);
      got[i] = s;
    end
    clk_bit(ackv, 1'b0, ack);
  endtask
  // Stop: data rises with clock high, then the clock stands still
  task automatic stop();
    SCL_CLK = 1'b0;
    mst_sda = 1'b0;
    #16;
    SCL_CLK = 1'b1;
    #8;
    mst_sda = 1'b1;
    #8;
  endtask
  task automatic idle_clocks(input int n);
    logic s;
    repeat (n) clk_bit(1'b1, 1'b0, s);
  endtask
endmodule
`default_nettype wire

// File: ascs_pkg.sv
`default_nettype none
package ascs_pkg;

  // ************************************************************
  // Conversion and serial framing constants
  // ************************************************************
  localparam int         RES_W        = 12;
  localparam logic [3:0] SAR_MSB      = 4'hb;
  localparam logic [3:0] SAR_LSB      = 4'h0;
  localparam logic [3:0] BIT_FIRST    = 4'h1;
  localparam logic [3:0] BIT_HOLD_EXT = 4'h2;
  localparam logic [3:0] BIT_LAST     = 4'h8;
  localparam logic [3:0] BIT_ACK      = 4'h9;
  localparam logic [3:0] BIT_IDLE     = 4'h0;
  localparam logic [3:0] RD_HEADER    = 4'hf;

  // ************************************************************
  // Setup and configuration byte fields, values after reset
  // ************************************************************
  localparam int         SETUP_EXT_BIT = 3;
  localparam int         SETUP_REF_LSB = 4;
  localparam int         CFG_SGL_BIT   = 0;
  localparam int         CFG_CS_LSB    = 1;
  localparam int         CFG_REP_LSB   = 5;
  localparam logic [6:0] SETUP_RST     = 7'h00;
  localparam logic [6:0] CFG_RST       = 7'h01;
  localparam logic [11:0] SAR_RST      = 12'h000;

  // Shared reference pin use
  typedef enum logic [1:0] {
    REF_AS_INPUT = 2'h0,
    REF_IN       = 2'h1,
    REF_OUT      = 2'h2
  } ascs_ref_e;

  // Link side frame phase
  typedef enum logic [3:0] {
    LK_IDLE  = 4'h1,
    LK_ADDR  = 4'h2,
    LK_WRITE = 4'h4,
    LK_READ  = 4'h8
  } ascs_link_e;

  // Converter side sequence
  typedef enum logic [2:0] {
    CV_IDLE  = 3'h1,
    CV_TRACK = 3'h2,
    CV_CONV  = 3'h4
  } ascs_conv_e;

  // Settings carried from the link domain to the converter domain
  typedef struct packed {
    logic       ext_clk;
    logic [1:0] ref_sel;
    logic [1:0] repeats;
    logic [3:0] chan;
    logic       single;
  } ascs_cfg_s;

  // One successive-approximation step: try bit idx, keep it if not above
  function automatic logic [11:0] ascs_sar_step(input logic [11:0] sar,
                                                input logic [3:0]  idx,
                                                input logic [11:0] level);
    logic [11:0] trial;
    trial = sar | (12'h001 << idx);
    return (trial <= level) ? trial : sar;
  endfunction

  // Bit of the 16-bit read word for a byte and a bit number 1..8
  function automatic logic ascs_out_bit(input logic [15:0] word,
                                        input logic        rd_byte,
                                        input logic [3:0]  bit_num);
    logic [3:0] p;
    p = {rd_byte, 3'(bit_num - 4'h1)};
    return word[4'hf - p];
  endfunction

endpackage
`default_nettype wire

// File: ascs_pkg_unused_marker.sv
`default_nettype none
`default_nettype wire

// File: ascs_sequencer.sv
// Function
// - Internal clock: track from eighth rising edge of address byte.
// - Internal clock: hold on falling edge of ninth (acknowledge) pulse.
// - Internal clock: convert on own clock, serial clock held low.
// - External clock: after valid read address, track from read bit edge.
// - External clock: hold on second rising edge of the first result byte.
// - External clock: conversion spans the next 12 serial clock cycles.
// - Every conversion resolves one bit per cycle over 12 cycles.
// - Acquisition lasts 1.5 clock periods internal, 3 periods external.
// - Single-ended: sample capacitor between chosen input and ground.
// - Differential: sample capacitor across the selected input pair.
// - Each result is a 12-bit value shifted out serially.
// - Multiplexer serves 4, 8 or 12 inputs per variant.
// - Setup setting makes shared pin analog input, reference in or out.
// - Pairing bit 1 means single-ended, 0 means differential.
// - Address byte low bit 0 means write, 1 means read.
// - Received byte with top bit 1 is setup, otherwise configuration.
// - External clock mode converts on the serial clock itself.
`timescale 1ns/100ps
`default_nettype none

module ascs_sequencer
  import ascs_pkg::*;
#(
  parameter int         N_CH       = 12,
  parameter logic [6:0] SLAVE_ADDR = 7'h35  // Arbitrary value
)(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        SCL_CLK,
  input  wire logic        BUS_START,
  input  wire logic        SDA_IN,
  input  wire logic [11:0] HELD_LEVEL,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  output logic             SCL_OUT,
  output logic             SCL_OE,
  output logic             TRACK,
  output logic [3:0]       MUX_POS,
  output logic [3:0]       MUX_NEG,
  output logic             MUX_NEG_GND,
  output logic [1:0]       REF_MODE,
  output logic [11:0]      RESULT,
  output logic             CONV_BUSY,
  output logic             EXT_CLK_MODE
);

  // ************************************************************
  // Variant check
  // ************************************************************
  generate
    if (!(N_CH == 4 || N_CH == 8 || N_CH == 12))
    begin : g_bad_n_ch
      $error("N_CH must be 4, 8 or 12");
    end
  endgenerate

  localparam logic [3:0] CH_TOP = 4'(N_CH - 1);

  // Clamp a channel code to the inputs this variant has
  function automatic logic [3:0] ascs_clip(input logic [3:0] c);
    return (c > CH_TOP) ? CH_TOP : c;
  endfunction

  // ************************************************************
  // State of both domains
  // ************************************************************
  typedef struct packed {
    logic [1:0]  rst_s;
    ascs_link_e  ph;
    logic [3:0]  cnt;
    logic [6:0]  sh;
    logic        rw_ok;
    logic        ack_rd;
    logic        rd_byte;
    logic        sda_oe;
    logic        drv_lo;
    logic [6:0]  setup;
    logic [6:0]  cfg_byte;
    logic        trk_t;
    logic        xh_t;
    logic [11:0] lv1;
    logic [11:0] lv2;
    logic        xbusy;
    logic [3:0]  xidx;
    logic [11:0] xsar;
  } ascs_link_s;

  typedef struct packed {
    logic [2:0]  scl_s;
    logic [1:0]  ack_s;
    logic [2:0]  trk_s;
    logic [2:0]  xh_s;
    ascs_cfg_s   cfg1;
    ascs_cfg_s   cfg2;
    ascs_cfg_s   cfg_mid;
    ascs_cfg_s   cfg_last;
    logic [11:0] lv1;
    logic [11:0] lv2;
    ascs_conv_e  st;
    logic [3:0]  idx;
    logic [1:0]  left;
    logic [11:0] sar;
    logic [11:0] result;
    logic        track;
    logic        scl_oe;
    logic        drv_lo;
    logic [3:0]  pos;
    logic [3:0]  neg;
    logic        gnd;
    logic [1:0]  ref_mode;
  } ascs_conv_s;

  ascs_link_s lk_reg;
  ascs_link_s lk_next;
  ascs_conv_s cv_reg;
  ascs_conv_s cv_next;
  ascs_cfg_s  cfg_src;

  // Settings as held in link flops, bundled for the crossing
  assign cfg_src = '{ext_clk: lk_reg.setup[SETUP_EXT_BIT],
                     ref_sel: lk_reg.setup[SETUP_REF_LSB +: 2],
                     repeats: lk_reg.cfg_byte[CFG_REP_LSB +: 2],
                     chan:    lk_reg.cfg_byte[CFG_CS_LSB +: 4],
                     single:  lk_reg.cfg_byte[CFG_SGL_BIT]};

  // ************************************************************
  // Link domain: serial clock rising edges
  // ************************************************************
  // In internal clock mode the result word reads the converter result directly; it is only
  // rewritten while the serial clock is held low, so it is static here.
  always_comb
  begin
    logic [3:0]  nb;
    logic [3:0]  nxt;
    logic [7:0]  rx;
    logic [15:0] word;
    logic        ext;
    lk_next = lk_reg;
    nb = (lk_reg.cnt == BIT_ACK) ? BIT_FIRST : lk_reg.cnt + 4'h1;
    nxt = (nb == BIT_ACK) ? BIT_FIRST : nb + 4'h1;
    rx = {lk_reg.sh, SDA_IN};
    ext = lk_reg.setup[SETUP_EXT_BIT];
    word = {RD_HEADER, ext ? lk_reg.xsar : cv_reg.result};
    lk_next.rst_s = {lk_reg.rst_s[0], RST_N};
    lk_next.lv1 = HELD_LEVEL;
    lk_next.lv2 = lk_reg.lv1;
    if (!lk_reg.rst_s[1])
    begin
      lk_next.ph = LK_IDLE;
      lk_next.cnt = BIT_IDLE;
      lk_next.sh = 7'h00;
      lk_next.rw_ok = 1'b0;
      lk_next.ack_rd = 1'b0;
      lk_next.rd_byte = 1'b0;
      lk_next.sda_oe = 1'b0;
      lk_next.drv_lo = 1'b0;
      lk_next.setup = SETUP_RST;
      lk_next.cfg_byte = CFG_RST;
      lk_next.trk_t = 1'b0;
      lk_next.xh_t = 1'b0;
      lk_next.xbusy = 1'b0;
      lk_next.xidx = SAR_MSB;
      lk_next.xsar = SAR_RST;
    end
    else
    begin
      // External conversion steps on the serial clock itself
      if (lk_reg.xbusy)
      begin
        lk_next.xsar = ascs_sar_step(lk_reg.xsar, lk_reg.xidx,
                                     lk_reg.lv2);
        lk_next.xbusy = (lk_reg.xidx != SAR_LSB);
        lk_next.xidx = lk_reg.xidx - 4'h1;
      end
      if (BUS_START)
      begin
        lk_next.ph = LK_ADDR;
        lk_next.cnt = BIT_FIRST;
        lk_next.sh = {6'h00, SDA_IN};
        lk_next.sda_oe = 1'b0;
        lk_next.ack_rd = 1'b0;
        lk_next.rd_byte = 1'b0;
      end
      else if (lk_reg.ph != LK_IDLE)
      begin
        lk_next.cnt = nb;
        lk_next.sda_oe = 1'b0;
        lk_next.ack_rd = 1'b0;
        if (nb == BIT_FIRST)
          lk_next.sh = {6'h00, SDA_IN};
        else if (nb <= BIT_LAST)
          lk_next.sh = rx[6:0];
        case (lk_reg.ph)
          LK_ADDR:
          begin
            if (nb == BIT_LAST)
            begin
              if (lk_reg.sh == SLAVE_ADDR)
              begin
                lk_next.sda_oe = 1'b1;
                lk_next.rw_ok = SDA_IN;
                if (SDA_IN)
                  lk_next.trk_t = ~lk_reg.trk_t;
              end
              else
                lk_next.ph = LK_IDLE;
            end
            else if (nb == BIT_ACK)
            begin
              if (lk_reg.rw_ok)
              begin
                lk_next.ph = LK_READ;
                lk_next.ack_rd = 1'b1;
                lk_next.sda_oe = ~ascs_out_bit(word, 1'b0, BIT_FIRST);
              end
              else
                lk_next.ph = LK_WRITE;
            end
          end
          LK_WRITE:
          begin
            if (nb == BIT_LAST)
            begin
              lk_next.sda_oe = 1'b1;
              if (rx[7])
                lk_next.setup = rx[6:0];
              else
                lk_next.cfg_byte = rx[6:0];
            end
          end
          LK_READ:
          begin
            if (nb == BIT_ACK)
            begin
              // A high acknowledge from the master ends the read
              if (SDA_IN)
                lk_next.ph = LK_IDLE;
              else
              begin
                lk_next.rd_byte = ~lk_reg.rd_byte;
                lk_next.sda_oe = ~ascs_out_bit(word, ~lk_reg.rd_byte,
                                               BIT_FIRST);
              end
            end
            else if (nb < BIT_LAST)
              lk_next.sda_oe = ~ascs_out_bit(word, lk_reg.rd_byte, nxt);
            if (ext && !lk_reg.rd_byte && nb == BIT_HOLD_EXT)
            begin
              lk_next.xh_t = ~lk_reg.xh_t;
              lk_next.xbusy = 1'b1;
              lk_next.xidx = SAR_MSB;
              lk_next.xsar = SAR_RST;
            end
          end
          default:
            lk_next.ph = LK_IDLE;
        endcase
      end
    end
  end

  // Link register; reset only takes effect while the link clock runs
  always_ff @(posedge SCL_CLK)
  begin
    lk_reg <= lk_next;
  end

  // ************************************************************
  // Converter domain: internal clock
  // ************************************************************
  always_comb
  begin
    logic        trk_edge;
    logic        xh_edge;
    logic        scl_fall;
    logic [11:0] step;
    cv_next = cv_reg;
    trk_edge = cv_reg.trk_s[2] ^ cv_reg.trk_s[1];
    xh_edge = cv_reg.xh_s[2] ^ cv_reg.xh_s[1];
    scl_fall = cv_reg.scl_s[2] & ~cv_reg.scl_s[1];
    step = ascs_sar_step(cv_reg.sar, cv_reg.idx, cv_reg.lv2);
    cv_next.scl_s = {cv_reg.scl_s[1:0], SCL_CLK};
    cv_next.ack_s = {cv_reg.ack_s[0], lk_reg.ack_rd};
    cv_next.trk_s = {cv_reg.trk_s[1:0], lk_reg.trk_t};
    cv_next.xh_s = {cv_reg.xh_s[1:0], lk_reg.xh_t};
    cv_next.cfg1 = cfg_src;
    cv_next.cfg_mid = cv_reg.cfg1;
    cv_next.cfg_last = cv_reg.cfg_mid;
    // Take a setting only once two synced samples agree, so a word
    // caught in mid-change never reaches the mux or the sequence
    if (cv_reg.cfg_mid == cv_reg.cfg_last)
      cv_next.cfg2 = cv_reg.cfg_mid;
    cv_next.lv1 = HELD_LEVEL;
    cv_next.lv2 = cv_reg.lv1;
    if (!RST_N)
    begin
      cv_next.st = CV_IDLE;
      cv_next.idx = SAR_MSB;
      cv_next.left = 2'h0;
      cv_next.sar = SAR_RST;
      cv_next.result = SAR_RST;
      cv_next.track = 1'b0;
      cv_next.scl_oe = 1'b0;
      cv_next.drv_lo = 1'b0;
      cv_next.pos = 4'h0;
      cv_next.neg = 4'h0;
      cv_next.gnd = 1'b1;
      cv_next.ref_mode = REF_AS_INPUT;
    end
    else
    begin
      // Reference pin use follows the setup setting
      case (cv_reg.cfg2.ref_sel)
        2'h0:    cv_next.ref_mode = REF_AS_INPUT;
        2'h1:    cv_next.ref_mode = REF_IN;
        default: cv_next.ref_mode = REF_OUT;
      endcase
      // Input routing is frozen while an internal clock conversion runs
      if (cv_reg.st != CV_CONV)
      begin
        if (cv_reg.cfg2.single)
        begin
          cv_next.pos = ascs_clip(cv_reg.cfg2.chan);
          cv_next.neg = 4'h0;
          cv_next.gnd = 1'b1;
        end
        else
        begin
          cv_next.pos = ascs_clip({cv_reg.cfg2.chan[3:1],
                                   cv_reg.cfg2.chan[0]});
          cv_next.neg = ascs_clip({cv_reg.cfg2.chan[3:1],
                                   ~cv_reg.cfg2.chan[0]});
          cv_next.gnd = 1'b0;
        end
      end
      case (cv_reg.st)
        CV_IDLE:
        begin
          if (trk_edge)
          begin
            cv_next.track = 1'b1;
            cv_next.st = CV_TRACK;
          end
        end
        CV_TRACK:
        begin
          if (!cv_reg.cfg2.ext_clk && scl_fall && cv_reg.ack_s[1])
          begin
            cv_next.track = 1'b0;
            cv_next.scl_oe = 1'b1;
            cv_next.st = CV_CONV;
            cv_next.sar = SAR_RST;
            cv_next.idx = SAR_MSB;
            cv_next.left = cv_reg.cfg2.repeats;
          end
          else if (cv_reg.cfg2.ext_clk && xh_edge)
          begin
            cv_next.track = 1'b0;
            cv_next.st = CV_IDLE;
          end
        end
        CV_CONV:
        begin
          cv_next.sar = step;
          cv_next.idx = cv_reg.idx - 4'h1;
          if (cv_reg.idx == SAR_LSB)
          begin
            if (cv_reg.left == 2'h0)
            begin
              cv_next.result = step;
              cv_next.scl_oe = 1'b0;
              cv_next.st = CV_IDLE;
            end
            else
            begin
              // Series: convert again on the same held sample
              cv_next.left = cv_reg.left - 2'h1;
              cv_next.idx = SAR_MSB;
              cv_next.sar = SAR_RST;
            end
          end
        end
        default:
          cv_next.st = CV_IDLE;
      endcase
    end
  end

  // Converter register
  always_ff @(posedge CLK)
  begin
    cv_reg <= cv_next;
  end

  // ************************************************************
  // Outputs, each straight from a flop
  // ************************************************************
  assign SDA_OUT      = lk_reg.drv_lo;        // Open drain: low only
  assign SDA_OE       = lk_reg.sda_oe;
  assign SCL_OUT      = cv_reg.drv_lo;
  assign SCL_OE       = cv_reg.scl_oe;
  assign TRACK        = cv_reg.track;
  assign MUX_POS      = cv_reg.pos;
  assign MUX_NEG      = cv_reg.neg;
  assign MUX_NEG_GND  = cv_reg.gnd;
  assign REF_MODE     = cv_reg.ref_mode;
  assign RESULT       = cv_reg.result;
  assign CONV_BUSY    = cv_reg.st[2];         // One-hot bit of CV_CONV
  assign EXT_CLK_MODE = lk_reg.setup[SETUP_EXT_BIT];

endmodule
`default_nettype wire

// File: ascs_sequencer_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker, converter clock domain
// ****************************************
module ascs_seq_props
  import ascs_pkg::*;
#(
  parameter int N_CH = 12
)(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [11:0] HELD_LEVEL,
  input wire logic        SCL_OE,
  input wire logic        TRACK,
  input wire logic [3:0]  MUX_POS,
  input wire logic [3:0]  MUX_NEG,
  input wire logic        MUX_NEG_GND,
  input wire logic [11:0] RESULT,
  input wire logic        CONV_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [5:0] busy_len_reg;
  // Length of the running burst; a multiple of 12 proves per-bit stepping
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !CONV_BUSY)
      busy_len_reg <= 6'h00;
    else
      busy_len_reg <= busy_len_reg + 6'h01;
  end
  property p_stretch;
    SCL_OE == CONV_BUSY;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock stretch and busy disagree");
  property p_hold_first;
    $rose(CONV_BUSY) |-> $fell(TRACK);
  endproperty
  a_hold_first: assert property (p_hold_first)
    else $error("conversion began without entering hold");
  property p_burst_len;
    $fell(CONV_BUSY) |-> busy_len_reg inside {6'h0c, 6'h18, 6'h24, 6'h30};
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("conversion burst length wrong");
  property p_result_level;
    $fell(CONV_BUSY) |-> RESULT == HELD_LEVEL;
  endproperty
  a_result_level: assert property (p_result_level)
    else $error("result differs from held level");
  property p_result_when;
    !$stable(RESULT) |-> $fell(CONV_BUSY);
  endproperty
  a_result_when: assert property (p_result_when)
    else $error("result changed outside conversion end");
  property p_mux_frozen;
    CONV_BUSY && $past(CONV_BUSY) |-> $stable({MUX_POS, MUX_NEG, MUX_NEG_GND});
  endproperty
  a_mux_frozen: assert property (p_mux_frozen)
    else $error("input routing moved while converting");
  property p_mux_range;
    {28'h0, MUX_POS} < N_CH && {28'h0, MUX_NEG} < N_CH;
  endproperty
  a_mux_range: assert property (p_mux_range)
    else $error("input select beyond channel count");
  property p_single_gnd;
    MUX_NEG_GND |-> MUX_NEG == 4'h0;
  endproperty
  a_single_gnd: assert property (p_single_gnd)
    else $error("negative side not parked in single mode");
  property p_track_len;
    $rose(TRACK) |=> TRACK [*8];
  endproperty
  a_track_len: assert property (p_track_len)
    else $error("acquisition cut short");
endmodule

bind ascs_sequencer ascs_seq_props #(.N_CH(N_CH)) u_props (
  .CLK(CLK), .RST_N(RST_N), .HELD_LEVEL(HELD_LEVEL), .SCL_OE(SCL_OE),
  .TRACK(TRACK), .MUX_POS(MUX_POS), .MUX_NEG(MUX_NEG),
  .MUX_NEG_GND(MUX_NEG_GND), .RESULT(RESULT), .CONV_BUSY(CONV_BUSY));
`default_nettype wire

// File: ascs_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Sequencer bench
// ****************************************
module ascs_sequencer_tb_top;
  localparam logic [6:0] ADDR = 7'h35;  // Arbitrary bus address
  logic        clk;
  logic        rst_n;
  logic [11:0] held_level;
  logic        scl_clk, bus_start, sda_in, sda_out, sda_oe, scl_out, scl_oe;
  logic        track, mux_neg_gnd, conv_busy, ext_clk_mode;
  logic [3:0]  mux_pos, mux_neg;
  logic [1:0]  ref_mode;
  logic [11:0] result;
  int          mismatches, checked, oe_cycles, trk_cycles;

  ascs_sequencer #(.N_CH(12), .SLAVE_ADDR(ADDR)) u_dut (
    .CLK(clk), .RST_N(rst_n), .SCL_CLK(scl_clk), .BUS_START(bus_start),
    .SDA_IN(sda_in), .HELD_LEVEL(held_level), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .TRACK(track),
    .MUX_POS(mux_pos), .MUX_NEG(mux_neg), .MUX_NEG_GND(mux_neg_gnd),
    .REF_MODE(ref_mode), .RESULT(result), .CONV_BUSY(conv_busy),
    .EXT_CLK_MODE(ext_clk_mode));
  ascs_i2c_mst u_mst (.SCL_CLK(scl_clk), .BUS_START(bus_start),
    .SDA_IN(sda_in), .SDA_OE(sda_oe), .SCL_OE(scl_oe));

  always #2 clk = ~clk;
  // Stretch and tracking spans, in converter cycles; sampled on the
  // falling edge, away from the edge that launches them
  always @(negedge clk)
  begin
    if (scl_oe === 1'b1) oe_cycles++;
    if (track === 1'b1) trk_cycles++;
  end

  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Off-grid start keeps bus edges unrelated to the converter clock
  task automatic gap();
    repeat (4) @(negedge clk);
    #1.3;
  endtask
  task automatic wr(input logic [7:0] b);
    logic [7:0] g;
    logic a;
    gap();
    u_mst.byte_x({ADDR, 1'b0}, 1'b1, 1'b1, g, a);
    chk("address ack", 16'h0, {15'h0, a});
    u_mst.byte_x(b, 1'b0, 1'b1, g, a);
    chk("data ack", 16'h0, {15'h0, a});
    u_mst.stop();
  endtask
  task automatic rd(output logic [15:0] w);
    logic [7:0] g;
    logic a;
    gap();
    u_mst.byte_x({ADDR, 1'b1}, 1'b1, 1'b1, g, a);
    chk("read ack", 16'h0, {15'h0, a});
    u_mst.byte_x(8'hff, 1'b0, 1'b0, w[15:8], a);
    u_mst.byte_x(8'hff, 1'b0, 1'b1, w[7:0], a);
    u_mst.stop();
  endtask

  task automatic t_reset();
    chk("reset flags", 16'h1, {8'h0, sda_out, scl_out, track, scl_oe,
        conv_busy, ext_clk_mode, sda_oe, mux_neg_gnd});
    chk("reset mux", 16'h0, {6'h0, mux_pos, mux_neg, ref_mode});
    chk("reset result", 16'h0, {4'h0, result});
    $display("reset test done");
  endtask
  // Setup bytes must not disturb the channel routing
  task automatic t_setup();
    for (int r = 0; r < 4; r++)
    begin
      wr({2'b10, 2'(r), 4'h6});
      repeat (4) @(negedge clk);
      chk("ref mode", (r < 2) ? 16'(r) : 16'h0002,
          {14'h0, ref_mode});
      chk("mux kept", 16'h1,
          {7'h0, mux_pos, mux_neg, mux_neg_gnd});
    end
    $display("setup test done");
  endtask
  task automatic t_mux();
    logic [7:0] cfg [5];
    logic [8:0] mux_exp [5];
    cfg = '{8'h0b, 8'h0a, 8'h04, 8'h1d, 8'h1a};
    mux_exp = '{9'h0a1, 9'h0a8, 9'h046, 9'h161, 9'h176};
    for (int i = 0; i < 5; i++)
    begin
      wr(cfg[i]);
      repeat (4) @(negedge clk);
      chk("routing", {7'h0, mux_exp[i]},
          {7'h0, mux_pos, mux_neg, mux_neg_gnd});
    end
    $display("mux test done");
  endtask
  // Every repeat count, with extreme levels
  task automatic t_int();
    logic [11:0] lv [4];
    logic [15:0] w;
    lv = '{12'hfff, 12'h000, 12'h5a3, 12'h801};
    for (int r = 0; r < 4; r++)
    begin
      wr({1'b0, 2'(r), 4'h0, 1'b1});
      @(negedge clk);
      held_level = lv[r];
      oe_cycles = 0;
      trk_cycles = 0;
      rd(w);
      chk("read word", {4'hf, lv[r]}, w);
      chk("result", {4'h0, lv[r]}, {4'h0, result});
      chk("stretch", 16'(12 * (r + 1)), 16'(oe_cycles));
      chk("track span", 16'h1,
          {15'h0, trk_cycles >= 10 && trk_cycles <= 13});
    end
    $display("internal clock test done");
  endtask
  // Bus clock converts; a slow master too
  task automatic t_ext();
    logic [15:0] w;
    wr(8'h88);
    chk("ext mode", 16'h1, {15'h0, ext_clk_mode});
    for (int s = 0; s < 2; s++)
    begin
      u_mst.stall_ns = 24 * s;
      @(negedge clk);
      held_level = (s == 0) ? 12'hc3e : 12'h0f1;
      oe_cycles = 0;
      rd(w);
      chk("ext word", {4'hf, held_level}, w);
      chk("ext stretch", 16'h0, 16'(oe_cycles));
      chk("ext result", 16'h0801, {4'h0, result});
    end
    u_mst.stall_ns = 0;
    wr(8'h80);
    $display("external clock test done");
  endtask
  task automatic t_addr();
    logic [7:0] g;
    logic a;
    gap();
    trk_cycles = 0;
    u_mst.byte_x({ADDR ^ 7'h01, 1'b1}, 1'b1, 1'b1, g, a);
    u_mst.stop();
    chk("foreign ack", 16'h1, {15'h0, a});
    wr(8'h0b);
    chk("write track", 16'h0, 16'(trk_cycles));
    $display("address test done");
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Run is near 17 us; this bound leaves ample margin
  initial
  begin
    #150000;
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end
  // Link reset needs bus clock edges while held
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    held_level = 12'h000;
    mismatches = 0;
    checked = 0;
    oe_cycles = 0;
    trk_cycles = 0;
    fork
      repeat (3) @(negedge clk);
      u_mst.idle_clocks(3);
    join
    @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    u_mst.idle_clocks(3);
    t_setup();
    t_mux();
    t_int();
    t_ext();
    t_addr();
    end_of_test();
  end
endmodule
`default_nettype wire
